// ===== logic/csd_pkg.sv
// Purpose: shared constants and types for the card-scan controller
// Assumes: 32-bit backplane addresses, byte-wide card registers except the 16-bit cached pointer
// Notes: host-side view of the card map; card registers are not held here
package csd_pkg;
    // ------------------------------------------------------------
    // backplane address map
    // ------------------------------------------------------------
    localparam logic [31:0] UNC_SLOT_SIZE = 32'h0040_0000;
    localparam logic [31:0] UNC_FIRST_BASE = 32'h0100_0000;
    localparam logic [7:0] UNC_FIRST_CODE = 8'h84;
    localparam logic [7:0] UNC_LAST_CODE = 8'hff;
    localparam logic [31:0] LEG_IO_BASE = 32'h0060_0000;
    localparam logic [31:0] LEG_SLOT_SIZE = 32'h0001_0000;
    localparam logic [4:0] LEG_LAST_CODE = 5'h1f;
    localparam logic [31:0] TOP_OF_SPACE = 32'hffff_fffc;
    localparam logic [31:0] LONG_WORD = 32'h0000_0004;
    localparam logic [31:0] MEG = 32'h0010_0000;
    // ------------------------------------------------------------
    // card register offsets
    // ------------------------------------------------------------
    localparam logic [31:0] CARD_ID_OFS = 32'h0000_0001;
    localparam logic [31:0] CARD_STATUS_OFS = 32'h0000_0003;
    localparam logic [31:0] CARD_EXT_ID_OFS = 32'h0000_0005;
    localparam logic [31:0] CACHED_PTR_OFS = 32'h0000_0008;
    localparam logic [31:0] EXTRA_SPACE_OFS = 32'h0000_0101;
    // ------------------------------------------------------------
    // apb register offsets of the controller
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RAM_BOT = 8'h08;
    localparam logic [7:0] REG_CARD_SEL = 8'h0c;
    localparam logic [7:0] REG_CARD_INFO = 8'h10;
    localparam logic [7:0] REG_CARD_BASE = 8'h14;
    localparam logic [7:0] REG_LEG_MAP = 8'h18;
    localparam logic [2:0] CTRL_SCAN_RAM = 3'd0;
    localparam logic [2:0] CTRL_SCAN_UNC = 3'd1;
    localparam logic [2:0] CTRL_SCAN_LEG = 3'd2;
    localparam int MAX_CARDS = 32;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic req;
        logic wr;
        logic [31:0] addr;
        logic [15:0] wdata;
    } csd_req_type;
    typedef struct packed {
        logic done;
        logic berr;
        logic [15:0] rdata;
    } csd_rsp_type;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] ident;
        logic [7:0] extra;
        logic [15:0] cached_ptr;
    } csd_card_type;
endpackage

// ===== logic/csd_bus_cycle.sv
// Purpose: one handshaked backplane read or write cycle
// Assumes: card answers with ack or bus error on async pins
// Notes: pins pass three flops, an answer counts when 2nd and 3rd agree, a release when the 2nd goes high
`timescale 1ns/1ps
module csd_bus_cycle (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire csd_pkg::csd_req_type req,
    output csd_pkg::csd_rsp_type rsp,
    output logic [31:0] bp_addr,
    output logic bp_strobe_n,
    output logic bp_read,
    output logic [15:0] bp_data_o,
    output logic bp_data_oe_n,
    input wire logic [15:0] bp_data_i,
    input wire logic bp_ack_n,
    input wire logic bp_berr_n
);
    import csd_pkg::*;
    typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_WAIT, CY_END}
        csd_cy_type;
    csd_cy_type st_q;
    logic [2:0] ack_sh_q;
    logic [2:0] berr_sh_q;
    logic ack_ok;
    logic berr_ok;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ack_sh_q <= 3'h7;
            berr_sh_q <= 3'h7;
        end else begin
            ack_sh_q <= {ack_sh_q[1:0], bp_ack_n};
            berr_sh_q <= {berr_sh_q[1:0], bp_berr_n};
        end
    end
    assign ack_ok = !ack_sh_q[1] && !ack_sh_q[2];
    assign berr_ok = !berr_sh_q[1] && !berr_sh_q[2];

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= CY_IDLE;
            rsp <= '0;
            bp_addr <= 32'h0;
            bp_strobe_n <= 1'b1;
            bp_read <= 1'b1;
            bp_data_o <= 16'h0;
            bp_data_oe_n <= 1'b1;
        end else begin
            rsp.done <= 1'b0;
            unique case (st_q)
                CY_IDLE: begin
                    if (req.req) begin
                        // address set up a full cycle ahead of the strobe
                        bp_addr <= req.addr;
                        bp_read <= !req.wr;
                        bp_data_o <= req.wdata;
                        bp_data_oe_n <= !req.wr;
                        st_q <= CY_SETUP;
                    end
                end
                CY_SETUP: begin
                    bp_strobe_n <= 1'b0;
                    st_q <= CY_WAIT;
                end
                CY_WAIT: begin
                    // no timeout: a missing card must answer with bus error
                    if (ack_ok || berr_ok) begin
                        rsp.rdata <= bp_data_i;
                        rsp.berr <= berr_ok;
                        bp_strobe_n <= 1'b1;
                        bp_data_oe_n <= 1'b1;
                        st_q <= CY_END;
                    end
                end
                CY_END: begin
                    // wait for the card to release its answer
                    if (!ack_ok && !berr_ok) begin
                        rsp.done <= 1'b1;
                        st_q <= CY_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ===== logic/csd_scan_ctrl.sv
// Purpose: host controller that sizes RAM and finds cards on the backplane
// Assumes: apb slave for software, one backplane cycle engine below
// Notes: scan results kept in a small card table read through apb
`timescale 1ns/1ps
module csd_scan_ctrl #(
    parameter int CARD_SLOTS = csd_pkg::MAX_CARDS
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] bp_addr,
    output logic bp_strobe_n,
    output logic bp_read,
    output logic [15:0] bp_data_o,
    output logic bp_data_oe_n,
    input wire logic [15:0] bp_data_i,
    input wire logic bp_ack_n,
    input wire logic bp_berr_n
);
    import csd_pkg::*;

    typedef enum logic [3:0] {
        SC_IDLE, SC_RAM, SC_UNC_ID, SC_UNC_EXTRA, SC_LEG_ID, SC_LEG_PTR,
        SC_STORE, SC_NEXT, SC_DONE
    } csd_sc_type;

    csd_sc_type st_q;
    csd_req_type req_q;
    csd_rsp_type rsp;
    csd_card_type cards_q [CARD_SLOTS];
    logic [5:0] ncards_q;
    logic [5:0] sel_q;
    logic [31:0] ram_bot_q;
    logic [31:0] probe_q;
    logic [7:0] code_q;
    logic [7:0] ident_q;
    logic [7:0] extra_q;
    logic [15:0] ptr_q;
    logic leg_mode_q;
    logic busy_q;
    logic done_q;
    logic leg_ptr_en_q;
    logic found_q;
    logic apb_wr;
    logic apb_rd;

    // ------------------------------------------------------------
    // backplane cycle engine
    // ------------------------------------------------------------
    csd_bus_cycle csd_bus_cycle_i (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .req(req_q),
        .rsp(rsp),
        .bp_addr(bp_addr),
        .bp_strobe_n(bp_strobe_n),
        .bp_read(bp_read),
        .bp_data_o(bp_data_o),
        .bp_data_oe_n(bp_data_oe_n),
        .bp_data_i(bp_data_i),
        .bp_ack_n(bp_ack_n),
        .bp_berr_n(bp_berr_n)
    );

    // ------------------------------------------------------------
    // apb slave, one wait state so read data comes from a flop
    // ------------------------------------------------------------
    assign apb_wr = psel && penable && pwrite && !pready;
    assign apb_rd = psel && penable && !pwrite && !pready;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0;
            if (apb_rd) begin
                unique case (paddr)
                    REG_CTRL: prdata <= {29'h0, 3'h0};
                    REG_STATUS: prdata <= {16'h0, 2'h0, ncards_q,
                                           6'h0, done_q, busy_q};
                    REG_RAM_BOT: prdata <= ram_bot_q;
                    REG_CARD_SEL: prdata <= {26'h0, sel_q};
                    REG_CARD_INFO: prdata <= {8'h0,
                        cards_q[sel_q[4:0]].code,
                        cards_q[sel_q[4:0]].ident,
                        cards_q[sel_q[4:0]].extra};
                    REG_CARD_BASE: prdata <= {16'h0,
                        cards_q[sel_q[4:0]].cached_ptr};
                    REG_LEG_MAP: prdata <= {31'h0, leg_ptr_en_q};
                    default: begin
                        prdata <= 32'h0;
                        pslverr <= 1'b1;
                    end
                endcase
            end else if (apb_wr) begin
                pslverr <= !(paddr == REG_CTRL || paddr == REG_CARD_SEL
                             || paddr == REG_LEG_MAP);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sel_q <= 6'h0;
            leg_ptr_en_q <= 1'b0;
        end else if (apb_wr) begin
            if (paddr == REG_CARD_SEL) begin
                sel_q <= pwdata[5:0];
            end
            // pointer at offset 8 is read from every legacy card that answers, only while bit 0 of REG_LEG_MAP is set
            if (paddr == REG_LEG_MAP) begin
                leg_ptr_en_q <= pwdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // scan sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= SC_IDLE;
            req_q <= '0;
            ram_bot_q <= 32'h0;
            probe_q <= 32'h0;
            code_q <= 8'h0;
            ident_q <= 8'h0;
            extra_q <= 8'h0;
            ptr_q <= 16'h0;
            ncards_q <= 6'h0;
            leg_mode_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            found_q <= 1'b0;
        end else begin
            req_q.req <= 1'b0;
            req_q.wr <= 1'b0;
            unique case (st_q)
                SC_IDLE: begin
                    if (apb_wr && paddr == REG_CTRL) begin
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        if (pwdata[CTRL_SCAN_RAM]) begin
                            // downward from top of space by long words
                            probe_q <= TOP_OF_SPACE;
                            ram_bot_q <= TOP_OF_SPACE + LONG_WORD;
                            req_q.req <= 1'b1;
                            req_q.addr <= TOP_OF_SPACE;
                            st_q <= SC_RAM;
                        end else if (pwdata[CTRL_SCAN_UNC]) begin
                            ncards_q <= 6'h0;
                            leg_mode_q <= 1'b0;
                            code_q <= UNC_FIRST_CODE;
                            probe_q <= UNC_FIRST_BASE;
                            st_q <= SC_NEXT;
                        end else if (pwdata[CTRL_SCAN_LEG]) begin
                            ncards_q <= 6'h0;
                            leg_mode_q <= 1'b1;
                            // legacy codes start at 0, slot 0 at 600000 hex
                            code_q <= 8'h0;
                            probe_q <= LEG_IO_BASE;
                            st_q <= SC_NEXT;
                        end else begin
                            busy_q <= 1'b0;
                        end
                    end
                end
                SC_RAM: begin
                    if (rsp.done) begin
                        if (rsp.berr || probe_q == 32'h0) begin
                            st_q <= SC_DONE;
                        end else begin
                            ram_bot_q <= probe_q;
                            probe_q <= probe_q - LONG_WORD;
                            req_q.req <= 1'b1;
                            req_q.addr <= probe_q - LONG_WORD;
                        end
                    end
                end
                SC_NEXT: begin
                    // issue id probe at offset 1 of the slot base
                    req_q.req <= 1'b1;
                    req_q.addr <= probe_q + CARD_ID_OFS;
                    st_q <= leg_mode_q ? SC_LEG_ID : SC_UNC_ID;
                end
                SC_UNC_ID: begin
                    if (rsp.done) begin
                        found_q <= !rsp.berr;
                        if (rsp.berr) begin
                            extra_q <= 8'h0;
                            st_q <= SC_STORE;
                        end else begin
                            ident_q <= rsp.rdata[7:0];
                            ptr_q <= 16'h0;
                            req_q.req <= 1'b1;
                            req_q.addr <= probe_q + EXTRA_SPACE_OFS;
                            st_q <= SC_UNC_EXTRA;
                        end
                    end
                end
                SC_UNC_EXTRA: begin
                    if (rsp.done) begin
                        extra_q <= rsp.berr ? 8'h0 : rsp.rdata[7:0];
                        st_q <= SC_STORE;
                    end
                end
                SC_LEG_ID: begin
                    if (rsp.done) begin
                        found_q <= !rsp.berr;
                        if (rsp.berr) begin
                            extra_q <= 8'h0;
                            st_q <= SC_STORE;
                        end else if (leg_ptr_en_q) begin
                            ident_q <= rsp.rdata[7:0];
                            req_q.req <= 1'b1;
                            req_q.addr <= probe_q + CACHED_PTR_OFS;
                            st_q <= SC_LEG_PTR;
                        end else begin
                            ident_q <= rsp.rdata[7:0];
                            ptr_q <= 16'h0;
                            extra_q <= 8'h0;
                            st_q <= SC_STORE;
                        end
                    end
                end
                SC_LEG_PTR: begin
                    if (rsp.done) begin
                        ptr_q <= rsp.berr ? 16'h0 : rsp.rdata;
                        extra_q <= 8'h0;
                        st_q <= SC_STORE;
                    end
                end
                SC_STORE: begin
                    st_q <= SC_NEXT;
                    // a card that answered is recorded while ncards_q is below CARD_SLOTS; empty slots are not
                    if (found_q && ncards_q < 6'(CARD_SLOTS)) begin
                        ncards_q <= ncards_q + 6'h1;
                    end
                    if (leg_mode_q) begin
                        // one 64 KB slot each, ends clear of the ram alias
                        if (code_q[4:0] == LEG_LAST_CODE) begin
                            st_q <= SC_DONE;
                        end else begin
                            code_q <= code_q + 8'h1;
                            probe_q <= probe_q + LEG_SLOT_SIZE;
                        end
                    end else begin
                        // skip extra megabytes rounded up to 4 MB slots
                        if ({1'b0, code_q} + {1'b0, extra_q[7:2]} + 9'h1
                            + {8'h0, |extra_q[1:0]} > 9'h0ff) begin
                            st_q <= SC_DONE;
                        end else begin
                            code_q <= code_q + {2'h0, extra_q[7:2]}
                                + {7'h0, |extra_q[1:0]} + 8'h1;
                            probe_q <= probe_q + UNC_SLOT_SIZE
                                + {8'h0, extra_q, 16'h0} * 32'h10
                                + (|extra_q[1:0] ? UNC_SLOT_SIZE
                                   - {10'h0, extra_q[1:0], 20'h0} : 32'h0)
                                - {10'h0, extra_q[1:0], 20'h0}
                                + {10'h0, extra_q[1:0], 20'h0};
                        end
                    end
                end
                SC_DONE: begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    st_q <= SC_IDLE;
                end
                default: st_q <= SC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // card table
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < CARD_SLOTS; i++) begin
                cards_q[i] <= '0;
            end
        end else if (st_q == SC_STORE && found_q
                     && ncards_q < 6'(CARD_SLOTS)) begin
            cards_q[ncards_q[4:0]] <= '{code: code_q, ident: ident_q,
                                        extra: extra_q, cached_ptr: ptr_q};
        end
    end
endmodule

// ===== testbench/csd_scan_ctrl_properties.sv
// Purpose: port timing checks for the card-scan controller
// Assumes: one clock domain, async active-high reset
// Notes: bound onto the controller from the bench top
`timescale 1ns/1ps
module csd_scan_ctrl_properties #(
    parameter int CARD_SLOTS = 32
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] bp_addr,
    input wire logic bp_strobe_n,
    input wire logic bp_read,
    input wire logic [15:0] bp_data_o,
    input wire logic bp_data_oe_n,
    input wire logic [15:0] bp_data_i,
    input wire logic bp_ack_n,
    input wire logic bp_berr_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer not one wait state");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    unmapped_err_a: assert property (psel && penable && !pready &&
        paddr > 8'h18 |=> pready && pslverr)
        else $error("unmapped address not refused");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    addr_held_a: assert property (!bp_strobe_n ##1 !bp_strobe_n
        |-> $stable(bp_addr)) else $error("address moved in cycle");
    strobe_waits_a: assert property (!bp_strobe_n && bp_ack_n &&
        bp_berr_n |=> !bp_strobe_n) else $error("strobe ended unanswered");
    no_restart_a: assert property (bp_strobe_n && !(bp_ack_n && bp_berr_n)
        |=> bp_strobe_n) else $error("cycle started before release");
    strobe_release_a: assert property (!bp_strobe_n && !bp_ack_n
        |-> ##[1:6] bp_strobe_n) else $error("strobe stuck after ack");
    internal_io_free_a: assert property (
        !bp_strobe_n |-> bp_addr[31:21] != 11'h002)
        else $error("internal io range accessed");
    write_drive_a: assert property (bp_data_oe_n && bp_read)
        else $error("scanner drove a write cycle");
    alias_window_free_a: assert property (
        !bp_strobe_n |-> bp_addr[31:23] != 9'h001)
        else $error("aliased ram window probed");
endmodule

// ===== testbench/csd_card_model.sv
// Purpose: backplane model with ram, two uncached cards, one legacy card
// Assumes: answer held until strobe rises, varying answer delay
// Notes: released data lines toggle so stale values never match
`timescale 1ns/1ps
module csd_card_model #(
    parameter logic [31:0] RAM_LO = 32'hffff_ffc0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [31:0] bp_addr,
    input wire logic bp_strobe_n,
    input wire logic [7:0] id_a,
    input wire logic [7:0] id_b,
    input wire logic [7:0] id_l,
    input wire logic [15:0] ptr_l,
    output logic [15:0] bp_data_i,
    output logic bp_ack_n,
    output logic bp_berr_n
);
    logic hit;
    logic [15:0] val;
    logic [1:0] wait_q;
    logic [1:0] slow_q;
    always_comb begin
        logic [7:0] code;
        code = 8'h84 + 8'((bp_addr - 32'h0100_0000) >> 22);
        hit = 1'b0;
        val = 16'h0000;
        if (bp_addr >= RAM_LO) begin
            hit = 1'b1;
        end else if (bp_addr >= 32'h0100_0000 && bp_addr < 32'h2000_0000
            && code <= 8'h87) begin
            hit = 1'b1;
            if (bp_addr[21:0] == 22'h1)
                val = {8'h00, (code == 8'h87) ? id_b : id_a};
            if (bp_addr[21:0] == 22'h101)
                val = (code == 8'h87) ? 16'h0000 : 16'h0008;
        end else if (bp_addr[31:16] == 16'h0069) begin
            hit = 1'b1;
            if (bp_addr[15:0] == 16'h1)
                val = {8'h00, id_l};
            if (bp_addr[15:0] == 16'h8)
                val = ptr_l;
        end
    end
    // writes change nothing here, the pointer stays a switch value
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            bp_ack_n <= 1'b1;
            bp_berr_n <= 1'b1;
            bp_data_i <= 16'h0000;
            wait_q <= 2'd0;
            slow_q <= 2'd0;
        end else if (bp_strobe_n) begin
            bp_ack_n <= 1'b1;
            bp_berr_n <= 1'b1;
            bp_data_i <= ~bp_data_i;
            wait_q <= 2'd0;
        end else if (bp_ack_n && bp_berr_n) begin
            if (wait_q == slow_q) begin
                bp_ack_n <= !hit;
                bp_berr_n <= hit;
                bp_data_i <= val;
                slow_q <= slow_q + 2'd1;
            end else begin
                wait_q <= wait_q + 2'd1;
            end
        end
    end
endmodule

// ===== testbench/tb_card_select_code_decoder.sv
// Purpose: self-checking bench for the card-scan controller
// Assumes: apb master tasks, backplane model on the far side
// Notes: ids and pointer are drawn from a fixed-seed xorshift
`timescale 1ns/1ps
module tb_card_select_code_decoder;
    import csd_pkg::*;
    localparam int CARD_SLOTS = 32;
    localparam logic [31:0] RAM_LO = 32'hffff_ffc0;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [7:0] paddr = 8'h00, id_a = 8'h01, id_b = 8'h01, id_l = 8'h01;
    logic [31:0] pwdata = 32'h0, prdata, rd, bp_addr, seed = 32'h70bbb4e9;
    logic bp_strobe_n, bp_read, bp_data_oe_n, bp_ack_n, bp_berr_n;
    logic [15:0] bp_data_o, bp_data_i, ptr_l = 16'h0000;
    int miscompares = 0, checked = 0, cycles = 0;
    always #20 clk_sys = ~clk_sys;
    csd_scan_ctrl #(.CARD_SLOTS(CARD_SLOTS)) csd_scan_ctrl_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bp_addr(bp_addr), .bp_strobe_n(bp_strobe_n),
        .bp_read(bp_read), .bp_data_o(bp_data_o),
        .bp_data_oe_n(bp_data_oe_n), .bp_data_i(bp_data_i),
        .bp_ack_n(bp_ack_n), .bp_berr_n(bp_berr_n));
    csd_card_model #(.RAM_LO(RAM_LO)) csd_card_model_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .bp_addr(bp_addr),
        .bp_strobe_n(bp_strobe_n), .id_a(id_a), .id_b(id_b), .id_l(id_l),
        .ptr_l(ptr_l), .bp_data_i(bp_data_i), .bp_ack_n(bp_ack_n),
        .bp_berr_n(bp_berr_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] info(input logic [7:0] c, i, e);
        return {8'h00, c, i, e};
    endfunction
    task automatic check(input string nm, input logic [31:0] s, x);
        checked++;
        if (s !== x) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // no fixed answer time assumed, only the bench timeout ends a hang
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic scan(input logic [31:0] mode, input logic [5:0] cnt);
        int n;
        n = 0;
        apb(1'b1, REG_CTRL, mode);
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 3000);
        check("scan done", {31'h0, rd[1]}, 32'h1);
        check("card count", {26'h0, rd[13:8]}, {26'h0, cnt});
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        check("strobe idle", {31'h0, bp_strobe_n}, 32'h1);
        apb(1'b0, 8'hfc, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
        $display("test reset done");
        scan(32'h1, 6'd0);
        apb(1'b0, REG_RAM_BOT, 32'h0);
        check("ram bottom", rd, RAM_LO);
        $display("test ram done");
        for (int k = 0; k < 2; k++) begin
            seed = xs(seed);
            id_a <= seed[7:0] | 8'h01;
            id_b <= seed[15:8] | 8'h01;
            scan(32'h2, 6'd2);
            apb(1'b1, REG_CARD_SEL, 32'h0);
            apb(1'b0, REG_CARD_INFO, 32'h0);
            check("card a", rd, info(8'h84, id_a, 8'h08));
            apb(1'b1, REG_CARD_SEL, 32'h1);
            apb(1'b0, REG_CARD_INFO, 32'h0);
            check("card b", rd, info(8'h87, id_b, 8'h00));
            $display("test uncached %0d done", k);
        end
        seed = xs(seed);
        id_l <= seed[7:0] | 8'h01;
        ptr_l <= seed[31:16];
        // pointer read first, then off: a stale pointer would show
        for (int j = 0; j < 2; j++) begin
            apb(1'b1, REG_LEG_MAP, {31'h0, j == 0});
            scan(32'h4, 6'd1);
            apb(1'b1, REG_CARD_SEL, 32'h0);
            apb(1'b0, REG_CARD_INFO, 32'h0);
            check("legacy card", rd & 32'h00ff_ff00,
                info(8'h09, id_l, 8'h00));
            apb(1'b0, REG_CARD_BASE, 32'h0);
            check("window ptr", rd & 32'h0000_ffff,
                (j == 0) ? {16'h0, ptr_l} : 32'h0);
            $display("test legacy %0d done", j);
        end
        report_and_stop();
    end
endmodule
bind csd_scan_ctrl csd_scan_ctrl_properties #(.CARD_SLOTS(CARD_SLOTS))
    csd_scan_ctrl_properties_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bp_addr(bp_addr),
    .bp_strobe_n(bp_strobe_n), .bp_read(bp_read), .bp_data_o(bp_data_o),
    .bp_data_oe_n(bp_data_oe_n), .bp_data_i(bp_data_i),
    .bp_ack_n(bp_ack_n), .bp_berr_n(bp_berr_n));
